// ===== hw/dmau_pkg.sv
// constants, types and register map of the data memory access unit
// assumes one cpu clock domain; shared by design and bench
package dmau_pkg;
   localparam logic [7:0]  OFS_MEMCTL  = 8'h00;
   localparam logic [7:0]  OFS_PTRSEL  = 8'h04;
   localparam logic [7:0]  OFS_PTR_LO  = 8'h08;
   localparam logic [7:0]  OFS_PTR_HI  = 8'h0C;
   localparam logic [7:0]  OFS_BANK    = 8'h10;
   localparam logic [7:0]  OFS_P2LATCH = 8'h14;
   localparam logic [7:0]  OFS_STATUS  = 8'h18;
   // memory_control_reg fields
   localparam int          MC_AO       = 0;
   localparam int          MC_OFFCHIP  = 1;
   localparam int          MC_SIZE_LO  = 2;
   localparam int          MC_PAGE     = 4;
   localparam int          MC_STRETCH  = 5;
   localparam logic [6:0]  MC_MASK     = 7'h7F;
   localparam logic [6:0]  MC_RESET    = 7'h0D;
   // pointer_select_reg fields
   localparam int          PS_SEL      = 0;
   localparam int          PS_FLAG     = 3;
   // program_status_word bank select positions
   localparam int          PSW_BANK_LO = 3;
   localparam logic [7:0]  P2_RESET    = 8'hFF;
   localparam logic [7:0]  BIT_BASE    = 8'h20;
   localparam logic [15:0] ONCHIP_EXPANDED_RAM_MIN    = 16'h0100;
   localparam logic [15:0] PAGE_LIMIT  = 16'h0100;
   localparam int          LOWER_DEPTH = 128;
   localparam int          UPPER_DEPTH = 128;
   localparam int          ONCHIP_EXPANDED_RAM_DEPTH  = 2048;
   // cycle counts in cpu clocks: 2 address + 3 strobe + 1 end = 6
   localparam logic [3:0]  ADDR_CYC    = 4'd2;
   localparam logic [3:0]  STROBE_NORM = 4'd3;
   localparam logic [3:0]  STROBE_LONG = 4'd15;
   localparam logic [1:0]  ALE_DIV     = 2'd3;
   localparam logic [1:0]  HTRANS_NONSEQ = 2'b10;

   typedef enum logic [2:0] {
      K_DIRECT, K_INDIRECT, K_REG, K_BIT, K_MOVX_RI, K_MOVX_PTR
   } kind_type;

   typedef enum logic [2:0] {
      T_LOWER, T_UPPER, T_SFR, T_ONCHIP_EXPANDED_RAM, T_EXT
   } target_type;

   typedef struct packed {
      logic       valid;
      kind_type   kind;
      logic       write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mem_req_type;

   typedef struct packed {
      logic       ack;
      target_type target;
      logic [7:0] rdata;
   } mem_rsp_type;

   typedef struct packed {
      logic       sel;
      logic       write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_type;
endpackage : dmau_pkg

// ===== hw/data_memory_access_unit.sv
// data memory access unit: internal ram segments, expanded ram, external muxed bus, dual pointer
// assumes an ahb-lite master for control registers and a cpu core issuing one access at a time
//
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps
module data_memory_access_unit (
   input  wire logic                  ref_clk,
   input  wire logic                  rst_n,
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic [31:0]                hrdata,
   output logic                       hreadyout,
   output logic                       hresp,
   input  wire dmau_pkg::mem_req_type cpu_req,
   output logic                       cpu_ready,
   output dmau_pkg::mem_rsp_type      cpu_rsp,
   output dmau_pkg::sfr_req_type      sfr_req,
   input  wire logic [7:0]            sfr_rdata,
   output logic [7:0]                 muxed_addr_data_out,
   output logic                       muxed_addr_data_oe_n,
   input  wire logic [7:0]            muxed_addr_data_in,
   output logic [7:0]                 upper_address,
   output logic                       ale,
   output logic                       p3_7_rd_n,
   output logic                       p3_6_wr_n
);
   import dmau_pkg::*;

   typedef enum logic [1:0] {EXT_IDLE, EXT_ADDR, EXT_STROBE, EXT_END} ext_state_type;

   logic [7:0]    lower_mem [LOWER_DEPTH];
   logic [7:0]    upper_mem [UPPER_DEPTH];
   logic [7:0]    onchip_expanded_ram_mem  [ONCHIP_EXPANDED_RAM_DEPTH];

   logic [6:0]    memory_control_reg_r;
   logic          pointer_select_r;
   logic          general_flag_r;
   logic [15:0]   data_pointer_a;
   logic [15:0]   data_pointer_b;
   logic [1:0]    bank_select_r;
   logic [7:0]    p2_latch_r;
   logic          ahb_wr_r;
   logic          ahb_rd_r;
   logic [7:0]    ahb_addr_r;
   logic [31:0]   hrdata_r;
   ext_state_type ext_state_r;
   logic [3:0]    ext_cnt_r;
   logic [15:0]   ext_addr_r;
   logic          ext_write_r;
   logic [7:0]    ext_wdata_r;
   logic          ext_hi_r;
   logic [1:0]    ale_div_r;
   logic          ack_r;
   target_type    target_r;
   logic [7:0]    rdata_r;

   // ahb decode
   wire           ahb_take    = hsel & hready & (htrans == HTRANS_NONSEQ);
   wire [7:0]     ahb_ofs     = ahb_addr_r;
   wire [15:0]    cur_ptr     = pointer_select_r ? data_pointer_b : data_pointer_a;
   wire           ao          = memory_control_reg_r[MC_AO];
   wire           offchip_ram_select = memory_control_reg_r[MC_OFFCHIP];
   wire [1:0]     expanded_ram_size  = memory_control_reg_r[MC_SIZE_LO +: 2];
   wire           page_access_enable = memory_control_reg_r[MC_PAGE];
   wire           strobe_stretch     = memory_control_reg_r[MC_STRETCH];
   wire [7:0]     ptrsel_rd   = {4'h0, general_flag_r, 1'b0, 1'b0, pointer_select_r};
   wire [7:0]     ptr_wbyte   = hwdata[7:0];
   wire           ptr_wr_lo   = ahb_wr_r & (ahb_ofs == OFS_PTR_LO);
   wire           ptr_wr_hi   = ahb_wr_r & (ahb_ofs == OFS_PTR_HI);

   // cpu access decode
   wire           accept      = cpu_req.valid & cpu_ready;
   wire           is_movx     = (cpu_req.kind == K_MOVX_RI) | (cpu_req.kind == K_MOVX_PTR);
   wire           is_ptr      = cpu_req.kind == K_MOVX_PTR;
   wire           to_sfr      = (cpu_req.kind == K_DIRECT) & cpu_req.addr[7];
   wire           to_upper    = (cpu_req.kind == K_INDIRECT) & cpu_req.addr[7];
   wire           to_lower    = ~is_movx & ~to_sfr & ~to_upper;
   wire [6:0]     reg_idx     = {2'b00, bank_select_r, cpu_req.addr[2:0]};
   wire [6:0]     bit_idx     = BIT_BASE[6:0] + {3'b000, cpu_req.addr[6:3]};
   wire [6:0]     lower_idx   = (cpu_req.kind == K_REG) ? reg_idx :
                                (cpu_req.kind == K_BIT) ? bit_idx : cpu_req.addr[6:0];
   wire [2:0]     bit_pos     = cpu_req.addr[2:0];
   wire [7:0]     lower_byte  = lower_mem[lower_idx];
   wire [15:0]    xaddr       = is_ptr ? cur_ptr : {8'h00, cpu_req.addr};
   wire [15:0]    onchip_expanded_ram_limit  = ONCHIP_EXPANDED_RAM_MIN << expanded_ram_size;
   wire           page_out    = page_access_enable & is_ptr & (xaddr >= PAGE_LIMIT);
   wire           to_onchip_expanded_ram     = is_movx & ~offchip_ram_select & (xaddr < onchip_expanded_ram_limit) & ~page_out;
   wire           to_ext      = is_movx & ~to_onchip_expanded_ram;
   wire           drive_hi    = is_ptr & ~page_access_enable;
   wire [10:0]    onchip_expanded_ram_idx    = xaddr[10:0];
   wire [7:0]     bit_wbyte   = (lower_byte & ~(8'h01 << bit_pos)) | ({7'h00, cpu_req.wdata[0]} << bit_pos);
   wire [3:0]     strobe_len  = strobe_stretch ? STROBE_LONG : STROBE_NORM;
   wire           ext_reading = ~ext_write_r & ((ext_state_r == EXT_STROBE) | (ext_state_r == EXT_END));

   // handshake and bus outputs
   assign cpu_ready   = ext_state_r == EXT_IDLE;
   assign hreadyout   = 1'b1;
   assign hresp       = 1'b0;
   assign hrdata      = hrdata_r;
   assign cpu_rsp     = '{ack: ack_r, target: target_r, rdata: rdata_r};
   assign sfr_req     = '{sel: accept & to_sfr, write: cpu_req.write, addr: cpu_req.addr, wdata: cpu_req.wdata};
   assign upper_address        = ext_hi_r & (ext_state_r != EXT_IDLE) ? ext_addr_r[15:8] : p2_latch_r;
   assign muxed_addr_data_out  = (ext_state_r == EXT_ADDR) ? ext_addr_r[7:0] : ext_wdata_r;
   assign muxed_addr_data_oe_n = (ext_state_r == EXT_IDLE) | ext_reading;
   assign p3_7_rd_n   = ~((ext_state_r == EXT_STROBE) & ~ext_write_r);
   assign p3_6_wr_n   = ~((ext_state_r == EXT_STROBE) & ext_write_r);
   // during an external cycle only the address pulse shows, so the free-running tick cannot mislatch
   assign ale = (ext_state_r != EXT_IDLE) ? ((ext_state_r == EXT_ADDR) & (ext_cnt_r == ADDR_CYC)) :
                (~ao & (ale_div_r == 2'd0));

   // ahb address phase capture
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ahb_wr_r   <= 1'b0;
         ahb_rd_r   <= 1'b0;
         ahb_addr_r <= 8'h00;
      end else begin
         ahb_wr_r   <= ahb_take & hwrite;
         ahb_rd_r   <= ahb_take & ~hwrite;
         ahb_addr_r <= ahb_take ? haddr[7:0] : ahb_addr_r;
      end
   end

   // read data prepared from the address phase so it is a flop in the data phase
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         hrdata_r <= 32'h0000_0000;
      end else if (ahb_take & ~hwrite) begin
         case (haddr[7:0])
            OFS_MEMCTL:  hrdata_r <= {25'h0, memory_control_reg_r};
            OFS_PTRSEL:  hrdata_r <= {24'h0, ptrsel_rd};
            OFS_PTR_LO:  hrdata_r <= {24'h0, cur_ptr[7:0]};
            OFS_PTR_HI:  hrdata_r <= {24'h0, cur_ptr[15:8]};
            OFS_BANK:    hrdata_r <= {27'h0, bank_select_r, 3'h0};
            OFS_P2LATCH: hrdata_r <= {24'h0, p2_latch_r};
            OFS_STATUS:  hrdata_r <= {31'h0, ~cpu_ready};
            default:     hrdata_r <= 32'h0000_0000;
         endcase
      end
   end

   // control registers written in the ahb data phase
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         memory_control_reg_r <= MC_RESET;
         pointer_select_r     <= 1'b0;
         general_flag_r       <= 1'b0;
         bank_select_r        <= 2'b00;
         p2_latch_r           <= P2_RESET;
      end else if (ahb_wr_r) begin
         case (ahb_ofs)
            OFS_MEMCTL: memory_control_reg_r <= hwdata[6:0] & MC_MASK;
            // bit 1 is not stored and bit 2 reads zero, so read+1 written back flips only the select
            OFS_PTRSEL: begin
               pointer_select_r <= hwdata[PS_SEL];
               general_flag_r   <= hwdata[PS_FLAG];
            end
            OFS_BANK:    bank_select_r <= hwdata[PSW_BANK_LO +: 2];
            OFS_P2LATCH: p2_latch_r    <= hwdata[7:0];
            default: ;
         endcase
      end
   end

   // both pointers sit behind one address pair; only the selected one takes the byte
   pointer_store pointer_store_a_inst (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .wr_lo   (ptr_wr_lo & ~pointer_select_r),
      .wr_hi   (ptr_wr_hi & ~pointer_select_r),
      .wbyte   (ptr_wbyte),
      .value_r (data_pointer_a)
   );

   pointer_store pointer_store_b_inst (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .wr_lo   (ptr_wr_lo & pointer_select_r),
      .wr_hi   (ptr_wr_hi & pointer_select_r),
      .wbyte   (ptr_wbyte),
      .value_r (data_pointer_b)
   );

   // ram arrays keep no reset: contents are undefined until software fills them
   always_ff @(posedge ref_clk) begin
      if (accept & cpu_req.write & to_lower) begin
         lower_mem[lower_idx] <= (cpu_req.kind == K_BIT) ? bit_wbyte : cpu_req.wdata;
      end
      if (accept & cpu_req.write & to_upper) begin
         upper_mem[cpu_req.addr[6:0]] <= cpu_req.wdata;
      end
      if (accept & cpu_req.write & to_onchip_expanded_ram) begin
         onchip_expanded_ram_mem[onchip_expanded_ram_idx] <= cpu_req.wdata;
      end
   end

   // free-running latch divider
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) ale_div_r <= 2'd0;
      else        ale_div_r <= (ale_div_r == ALE_DIV - 2'd1) ? 2'd0 : ale_div_r + 2'd1;
   end

   // external bus cycle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_state_r <= EXT_IDLE;
         ext_cnt_r   <= 4'd0;
         ext_addr_r  <= 16'h0000;
         ext_write_r <= 1'b0;
         ext_wdata_r <= 8'h00;
         ext_hi_r    <= 1'b0;
      end else begin
         case (ext_state_r)
            EXT_IDLE: if (accept & to_ext) begin
               ext_state_r <= EXT_ADDR;
               ext_cnt_r   <= ADDR_CYC;
               ext_addr_r  <= xaddr;
               ext_write_r <= cpu_req.write;
               ext_wdata_r <= cpu_req.wdata;
               ext_hi_r    <= drive_hi;
            end
            EXT_ADDR: begin
               ext_cnt_r <= ext_cnt_r - 4'd1;
               if (ext_cnt_r == 4'd1) begin
                  ext_state_r <= EXT_STROBE;
                  ext_cnt_r   <= strobe_len;
               end
            end
            EXT_STROBE: begin
               ext_cnt_r <= ext_cnt_r - 4'd1;
               if (ext_cnt_r == 4'd1) ext_state_r <= EXT_END;
            end
            EXT_END: ext_state_r <= EXT_IDLE;
            default: ext_state_r <= EXT_IDLE;
         endcase
      end
   end

   // cpu answer: internal next cycle, external one cycle after the strobe ends
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_r    <= 1'b0;
         target_r <= T_LOWER;
         rdata_r  <= 8'h00;
      end else begin
         ack_r <= (accept & ~to_ext) | (ext_state_r == EXT_END);
         if (accept) begin
            if (to_ext)        target_r <= T_EXT;
            else if (to_onchip_expanded_ram)  target_r <= T_ONCHIP_EXPANDED_RAM;
            else if (to_sfr)   target_r <= T_SFR;
            else if (to_upper) target_r <= T_UPPER;
            else               target_r <= T_LOWER;
         end
         if (accept & to_lower)
            rdata_r <= (cpu_req.kind == K_BIT) ? {7'h00, lower_byte[bit_pos]} : lower_byte;
         else if (accept & to_upper)
            rdata_r <= upper_mem[cpu_req.addr[6:0]];
         else if (accept & to_onchip_expanded_ram)
            rdata_r <= onchip_expanded_ram_mem[onchip_expanded_ram_idx];
         else if (accept & to_sfr)
            rdata_r <= sfr_rdata;
         else if ((ext_state_r == EXT_STROBE) & ~ext_write_r & (ext_cnt_r == 4'd1))
            rdata_r <= muxed_addr_data_in;
      end
   end
endmodule : data_memory_access_unit

// one data pointer, written a byte at a time over the register bus
module pointer_store (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        wr_lo,
   input  wire logic        wr_hi,
   input  wire logic [7:0]  wbyte,
   output logic      [15:0] value_r
);
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         value_r <= 16'h0000;
      end else begin
         if (wr_lo) value_r[7:0] <= wbyte;
         if (wr_hi) value_r[15:8] <= wbyte;
      end
   end
endmodule : pointer_store

// ===== sim/dmau_checker_sva.sv
// checker: strobe, port 0 and answer timing of the data memory access unit
// assumes it is bound onto the unit's top ports, one clock domain
`timescale 1ns/100ps
module dmau_checker (
   input wire logic                  ref_clk,
   input wire logic                  rst_n,
   input wire dmau_pkg::mem_req_type cpu_req,
   input wire logic                  cpu_ready,
   input wire dmau_pkg::mem_rsp_type cpu_rsp,
   input wire dmau_pkg::sfr_req_type sfr_req,
   input wire logic                  muxed_addr_data_oe_n,
   input wire logic                  ale,
   input wire logic                  p3_7_rd_n,
   input wire logic                  p3_6_wr_n
);
   import dmau_pkg::*;
   logic [4:0] low_len_r;
   wire        idle = p3_7_rd_n & p3_6_wr_n;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // a repetition cannot reach 15 cycles, so the low time is counted here
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) low_len_r <= 5'h0;
      else if (!idle) low_len_r <= low_len_r + 5'h1;
      else low_len_r <= 5'h0;
   end
   chk_strobe_width: assert property ($rose(idle) |-> low_len_r == 5'h3 || low_len_r == 5'hF)
      else $error("strobe width wrong");
   chk_ack_after: assert property ($rose(idle) |-> ##1 cpu_rsp.ack)
      else $error("no answer after strobe");
   chk_latch_lead: assert property ($fell(idle) |-> $past(ale, 2) && !cpu_ready)
      else $error("no latch pulse before strobe");
   chk_addr_drive: assert property (ale && !cpu_ready |-> !muxed_addr_data_oe_n)
      else $error("low address not driven");
   chk_read_float: assert property (!p3_7_rd_n |-> muxed_addr_data_oe_n)
      else $error("port 0 driven in read");
   chk_write_drive: assert property (!p3_6_wr_n |-> !muxed_addr_data_oe_n)
      else $error("write data not driven");
   chk_one_strobe: assert property (p3_7_rd_n || p3_6_wr_n)
      else $error("both strobes low");
   chk_sfr_route: assert property (sfr_req.sel |-> cpu_req.kind == K_DIRECT && cpu_req.addr[7]
      ##1 cpu_rsp.ack && cpu_rsp.target == T_SFR)
      else $error("special register route wrong");
endmodule : dmau_checker

bind data_memory_access_unit dmau_checker dmau_checker_inst (.ref_clk, .rst_n, .cpu_req, .cpu_ready,
   .cpu_rsp, .sfr_req, .muxed_addr_data_oe_n, .ale, .p3_7_rd_n, .p3_6_wr_n);

// ===== sim/ext_ram_model.sv
// partner: external byte memory on the muxed address/data bus
// assumes one access at a time; READ_DELAY makes a slow device
`timescale 1ns/100ps
module ext_ram_model #(
   parameter int READ_DELAY = 0
) (
   input  wire logic       ref_clk,
   input  wire logic [7:0] ad_out,
   input  wire logic       ad_oe_n,
   input  wire logic [7:0] upper_address,
   input  wire logic       ale,
   input  wire logic       rd_n,
   input  wire logic       wr_n,
   output logic [7:0]      ad_in
);
   logic [7:0]  mem [0:65535];
   logic [15:0] addr_r;
   logic [7:0]  last_r;
   int          rd_cnt;
   always @(posedge ref_clk) begin
      if (ale && !ad_oe_n) addr_r <= {upper_address, ad_out};
      if (!wr_n) mem[addr_r] <= ad_out;
      rd_cnt <= rd_n ? 0 : rd_cnt + 1;
      last_r <= ad_in;
   end
   // undriven lines show the inverse of the last level: port 0 has no pull-up
   assign ad_in = (!rd_n && rd_cnt >= READ_DELAY) ? mem[addr_r] : !ad_oe_n ? ad_out : ~last_r;
endmodule : ext_ram_model

// ===== sim/test_data_memory_access_unit.sv
// testbench: registers, ram segments and external bus of the data memory access unit
// assumes the external memory model and the bound checker
`timescale 1ns/100ps
module test_data_memory_access_unit;
   import dmau_pkg::*;
   logic        ref_clk = 1'h0;
   logic        rst_n   = 1'h0;
   logic        hsel    = 1'h0;
   logic        hwrite  = 1'h0;
   logic [1:0]  htrans  = 2'h0;
   logic [31:0] haddr   = 32'h0;
   logic [31:0] hwdata  = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout, hresp, cpu_ready, ad_oe_n, ale, rd_n, wr_n;
   logic [7:0]  ad_out, ad_in, upper_address;
   mem_req_type cpu_req = '0;
   mem_rsp_type cpu_rsp;
   int          errors = 0, tests_run = 0, cycles = 0, lat, low, n;

   always #5 ref_clk = ~ref_clk;
   data_memory_access_unit data_memory_access_unit_inst (.ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .cpu_req, .cpu_ready, .cpu_rsp,
      .sfr_req(), .sfr_rdata(8'h3C), .muxed_addr_data_out(ad_out), .muxed_addr_data_oe_n(ad_oe_n),
      .muxed_addr_data_in(ad_in), .upper_address, .ale, .p3_7_rd_n(rd_n), .p3_6_wr_n(wr_n));
   ext_ram_model #(.READ_DELAY(2)) ext_ram_model_inst (.ref_clk, .ad_out, .ad_oe_n, .upper_address, .ale,
      .rd_n, .wr_n, .ad_in);

   task automatic conclude();
      $display("compares %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : conclude
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         conclude();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask : chk
   task automatic ahb(input logic w, input logic [7:0] ofs, input logic [7:0] d, output logic [31:0] r);
      @(posedge ref_clk);
      hsel   <= 1'h1;
      haddr  <= {24'h0, ofs};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge ref_clk); while (hreadyout !== 1'h1);
      hsel   <= 1'h0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge ref_clk); while (hreadyout !== 1'h1);
      r = hrdata;
   endtask : ahb
   task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
      logic [31:0] v;
      ahb(1'h1, ofs, d, v);
   endtask : wr
   task automatic rd(input logic [7:0] ofs, input logic [31:0] e);
      logic [31:0] v;
      ahb(1'h0, ofs, 8'h0, v);
      chk(v, e);
   endtask : rd
   task automatic setptr(input logic [15:0] p);
      wr(OFS_PTR_HI, p[15:8]);
      wr(OFS_PTR_LO, p[7:0]);
   endtask : setptr
   // one cpu access; lat counts edges to the answer, low the strobe-low edges
   task automatic cpu(input kind_type k, input logic w, input logic [7:0] a, input logic [7:0] d,
                      input target_type t, input logic [7:0] e);
      @(posedge ref_clk);
      cpu_req <= '{1'h1, k, w, a, d};
      do @(posedge ref_clk); while (cpu_ready !== 1'h1);
      cpu_req.valid <= 1'h0;
      lat = 0;
      low = 0;
      do begin
         @(posedge ref_clk);
         lat++;
         if (rd_n === 1'h0 || wr_n === 1'h0) low++;
      end while (cpu_rsp.ack !== 1'h1 && lat < 40);
      chk(32'(cpu_rsp.ack), 32'h1);
      chk(32'(cpu_rsp.target), 32'(t));
      if (!w) chk(32'(cpu_rsp.rdata), 32'(e));
   endtask : cpu
   task automatic t_regs();
      rd(OFS_MEMCTL, 32'h0D);
      rd(OFS_PTRSEL, 32'h0);
      wr(OFS_PTRSEL, 8'h0D);
      rd(OFS_PTRSEL, 32'h09);
      wr(OFS_PTRSEL, 8'h0A);
      rd(OFS_PTRSEL, 32'h08);
      rd(8'h1C, 32'h0);
      wr(OFS_PTR_LO, 8'h11);
      wr(OFS_PTRSEL, 8'h01);
      wr(OFS_PTR_LO, 8'h22);
      rd(OFS_PTR_LO, 32'h22);
      wr(OFS_PTRSEL, 8'h00);
      rd(OFS_PTR_LO, 32'h11);
      $display("regs done");
   endtask : t_regs
   task automatic t_int();
      cpu(K_DIRECT, 1'h1, 8'h05, 8'hA1, T_LOWER, 8'h0);
      cpu(K_INDIRECT, 1'h0, 8'h05, 8'h0, T_LOWER, 8'hA1);
      for (int b = 0; b < 4; b++) begin
         wr(OFS_BANK, 8'(b * 8));
         cpu(K_REG, 1'h1, 8'h03, 8'(8'hB0 + b), T_LOWER, 8'h0);
         cpu(K_DIRECT, 1'h0, 8'(b * 8 + 3), 8'h0, T_LOWER, 8'(8'hB0 + b));
      end
      cpu(K_DIRECT, 1'h1, 8'h2F, 8'h0, T_LOWER, 8'h0);
      cpu(K_BIT, 1'h1, 8'h7F, 8'h01, T_LOWER, 8'h0);
      cpu(K_DIRECT, 1'h0, 8'h2F, 8'h0, T_LOWER, 8'h80);
      cpu(K_BIT, 1'h0, 8'h7F, 8'h0, T_LOWER, 8'h01);
      cpu(K_BIT, 1'h0, 8'h78, 8'h0, T_LOWER, 8'h00);
      cpu(K_INDIRECT, 1'h1, 8'h90, 8'hA5, T_UPPER, 8'h0);
      cpu(K_DIRECT, 1'h0, 8'h90, 8'h0, T_SFR, 8'h3C);
      cpu(K_INDIRECT, 1'h0, 8'h90, 8'h0, T_UPPER, 8'hA5);
      $display("internal done");
   endtask : t_int
   task automatic t_ext();
      wr(OFS_MEMCTL, 8'h0F);
      setptr(16'h1234);
      cpu(K_MOVX_PTR, 1'h1, 8'h0, 8'h5A, T_EXT, 8'h0);
      chk(32'(lat), 32'h7);
      chk(32'(low), 32'h3);
      chk(32'(ext_ram_model_inst.mem[16'h1234]), 32'h5A);
      wr(OFS_MEMCTL, 8'h2F);
      // the location was written above, so the read does not see power-up contents
      cpu(K_MOVX_PTR, 1'h0, 8'h0, 8'h0, T_EXT, 8'h5A);
      chk(32'(lat), 32'h13);
      chk(32'(low), 32'hF);
      wr(OFS_P2LATCH, 8'h77);
      cpu(K_MOVX_RI, 1'h1, 8'h33, 8'hC3, T_EXT, 8'h0);
      chk(32'(ext_ram_model_inst.mem[16'h7733]), 32'hC3);
      $display("external done");
   endtask : t_ext
   task automatic t_page();
      wr(OFS_MEMCTL, 8'h11);
      setptr(16'h0340);
      cpu(K_MOVX_PTR, 1'h1, 8'h0, 8'hD4, T_EXT, 8'h0);
      chk(32'(ext_ram_model_inst.mem[16'h7740]), 32'hD4);
      setptr(16'h0040);
      cpu(K_MOVX_PTR, 1'h1, 8'h0, 8'hE5, T_ONCHIP_EXPANDED_RAM, 8'h0);
      cpu(K_MOVX_PTR, 1'h0, 8'h0, 8'h0, T_ONCHIP_EXPANDED_RAM, 8'hE5);
      $display("page done");
   endtask : t_page
   task automatic t_size();
      for (int s = 0; s < 4; s++) begin
         wr(OFS_MEMCTL, 8'(1 + 4 * s));
         setptr(16'((256 << s) - 1));
         cpu(K_MOVX_PTR, 1'h1, 8'h0, 8'h0, T_ONCHIP_EXPANDED_RAM, 8'h0);
         setptr(16'(256 << s));
         cpu(K_MOVX_PTR, 1'h1, 8'h0, 8'h0, T_EXT, 8'h0);
      end
      $display("size done");
   endtask : t_size
   task automatic t_ale();
      for (int i = 0; i < 2; i++) begin
         wr(OFS_MEMCTL, 8'(8'h0C + i));
         n = 0;
         repeat (30) begin
            @(posedge ref_clk);
            if (ale === 1'h1) n++;
         end
         chk(32'(n), 32'(10 - 10 * i));
      end
      $display("latch strobe done");
   endtask : t_ale
   initial begin
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'h1;
      t_regs();
      t_int();
      t_ext();
      t_page();
      t_size();
      t_ale();
      conclude();
   end
endmodule : test_data_memory_access_unit
